//--- core/dcag_pkg.sv
// Constants for the DMA channel counter and address generator
package dcag_pkg;
    localparam int DCAG_W = 24;
    localparam int DCAG_AW = 3;
    // ---------------------------------------------------------
    // Register indices
    // ---------------------------------------------------------
    localparam logic [2:0] DCAG_REG_COUNT = 3'h0;
    localparam logic [2:0] DCAG_REG_SRC = 3'h1;
    localparam logic [2:0] DCAG_REG_DST = 3'h2;
    localparam logic [2:0] DCAG_REG_CTRL = 3'h3;
    localparam logic [2:0] DCAG_REG_OFF0 = 3'h4;
    localparam logic [2:0] DCAG_REG_OFF1 = 3'h5;
    localparam logic [2:0] DCAG_REG_STAT = 3'h6;
    localparam logic [2:0] DCAG_REG_DCNT = 3'h7;
    // ---------------------------------------------------------
    // Control and status fields
    // ---------------------------------------------------------
    localparam int DCAG_CTRL_SMODE = 0;
    localparam int DCAG_CTRL_DMODE = 3;
    localparam int DCAG_CTRL_SSTEP = 6;
    localparam int DCAG_CTRL_DSTEP = 7;
    localparam int DCAG_CTRL_RUN = 8;
    localparam int DCAG_STAT_DONE = 0;
    localparam int DCAG_STAT_FULL = 1;
    localparam int DCAG_STAT_EMPTY = 2;
    localparam logic [23:0] DCAG_RESET = 24'h000000;
    // ---------------------------------------------------------
    // Counter structures and their field masks
    // ---------------------------------------------------------
    localparam logic [2:0] DCAG_MODE_A = 3'h0;
    localparam logic [2:0] DCAG_MODE_B = 3'h1;
    localparam logic [2:0] DCAG_MODE_C = 3'h2;
    localparam logic [2:0] DCAG_MODE_D = 3'h3;
    localparam logic [2:0] DCAG_MODE_E = 3'h4;
    localparam logic [23:0] DCAG_LO_ALL = 24'hFFFFFF;
    localparam logic [23:0] DCAG_LO_12 = 24'h000FFF;
    localparam logic [23:0] DCAG_LO_6 = 24'h00003F;
    localparam logic [23:0] DCAG_MI_C = 24'h000FC0;
    localparam logic [23:0] DCAG_MI_D = 24'h03FFC0;
    localparam logic [23:0] DCAG_MI_E = 24'h03F000;
    localparam logic [23:0] DCAG_ONE_12 = 24'h001000;
    localparam logic [23:0] DCAG_ONE_18 = 24'h040000;
    localparam logic [23:0] DCAG_ONE_6 = 24'h000040;
    localparam int DCAG_FIFO_DEPTH = 16;
endpackage

//--- core/dcag_core.sv
// Channel counter, address sequencer and address FIFO
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

// -------------------------------------------------------------
// Address-pair FIFO
// -------------------------------------------------------------
module dcag_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] level;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (level != (PW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            end
            level <= level + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    AST_FIFO_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
        level <= (PW+1)'(DEPTH)) else $error("FIFO level beyond depth");
endmodule

// -------------------------------------------------------------
// Channel top
// -------------------------------------------------------------
module dcag_channel
    import dcag_pkg::*;
#(
    parameter int DEPTH = DCAG_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [DCAG_AW-1:0] reg_addr,
    input wire logic [DCAG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DCAG_W-1:0] reg_rdata,
    input wire logic xfer_req,
    output logic xfer_ready,
    output logic addr_valid,
    input wire logic addr_ready,
    output logic [DCAG_W-1:0] addr_src,
    output logic [DCAG_W-1:0] addr_dst
);
    // ---------------------------------------------------------
    // Structure decode
    // ---------------------------------------------------------
    function automatic logic [23:0] lo_mask(input logic [2:0] m);
        case (m)
            DCAG_MODE_A: lo_mask = DCAG_LO_ALL;
            DCAG_MODE_B: lo_mask = DCAG_LO_12;
            DCAG_MODE_C: lo_mask = DCAG_LO_6;
            DCAG_MODE_D: lo_mask = DCAG_LO_6;
            DCAG_MODE_E: lo_mask = DCAG_LO_12;
            default: lo_mask = DCAG_LO_ALL;
        endcase
    endfunction

    function automatic logic [23:0] mi_mask(input logic [2:0] m);
        case (m)
            DCAG_MODE_C: mi_mask = DCAG_MI_C;
            DCAG_MODE_D: mi_mask = DCAG_MI_D;
            DCAG_MODE_E: mi_mask = DCAG_MI_E;
            default: mi_mask = 24'h000000;
        endcase
    endfunction

    // Weight of the least bit of the high field
    function automatic logic [23:0] hi_one(input logic [2:0] m);
        case (m)
            DCAG_MODE_B: hi_one = DCAG_ONE_12;
            DCAG_MODE_C: hi_one = DCAG_ONE_12;
            DCAG_MODE_D: hi_one = DCAG_ONE_18;
            DCAG_MODE_E: hi_one = DCAG_ONE_18;
            default: hi_one = 24'h000000;
        endcase
    endfunction

    function automatic logic [23:0] mi_one(input logic [2:0] m);
        case (m)
            DCAG_MODE_E: mi_one = DCAG_ONE_12;
            default: mi_one = DCAG_ONE_6;
        endcase
    endfunction

    // Next count; a nonzero low field never borrows upward
    function automatic logic [23:0] cnt_step(input logic [2:0] m, input logic [23:0] c, input logic [23:0] p);
        logic [23:0] lm;
        logic [23:0] mm;
        lm = lo_mask(m);
        mm = mi_mask(m);
        if ((c & lm) != 24'h000000) begin
            cnt_step = c - 24'h000001;
        end else if ((c & mm) != 24'h000000) begin
            cnt_step = (c - mi_one(m)) | (p & lm);
        end else if (c != 24'h000000) begin
            cnt_step = (c - hi_one(m)) | (p & (lm | mm));
        end else begin
            cnt_step = p;
        end
    endfunction

    // Address increment for this step
    function automatic logic [23:0] addr_delta(input logic [2:0] m, input logic [23:0] c, input logic st,
                                               input logic [23:0] o0, input logic [23:0] o1);
        logic [23:0] lm;
        lm = lo_mask(m);
        // Codes above E decode as single, so they step like it too
        if (lm == DCAG_LO_ALL) begin
            addr_delta = st ? 24'h000001 : 24'h000000;
        end else if ((c & lm) != 24'h000000) begin
            addr_delta = 24'h000001;
        end else if (m == DCAG_MODE_B) begin
            addr_delta = o0;
        end else if ((c & mi_mask(m)) != 24'h000000) begin
            addr_delta = o0;
        end else begin
            addr_delta = o1;
        end
    endfunction

    // ---------------------------------------------------------
    // State
    // ---------------------------------------------------------
    logic [23:0] preload;
    logic [23:0] src_cnt;
    logic [23:0] dst_cnt;
    logic [23:0] src_ptr;
    logic [23:0] dst_ptr;
    logic [23:0] off0;
    logic [23:0] off1;
    logic [8:0] ctrl;
    logic done;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [47:0] fifo_out;

    wire [2:0] smode = ctrl[DCAG_CTRL_SMODE +: 3];
    wire [2:0] dmode = ctrl[DCAG_CTRL_DMODE +: 3];
    wire run = ctrl[DCAG_CTRL_RUN];
    // A step needs room in the FIFO, so a stalled sink halts counting
    wire step = xfer_req && run && fifo_in_ready;
    wire wr_cnt = reg_wr && (reg_addr == DCAG_REG_COUNT);
    wire src_last = (src_cnt == 24'h000000);
    wire [23:0] next_src_cnt = cnt_step(smode, src_cnt, preload);
    wire [23:0] next_dst_cnt = cnt_step(dmode, dst_cnt, preload);
    wire [23:0] next_src_ptr = src_ptr + addr_delta(smode, src_cnt, ctrl[DCAG_CTRL_SSTEP], off0, off1);
    wire [23:0] next_dst_ptr = dst_ptr + addr_delta(dmode, dst_cnt, ctrl[DCAG_CTRL_DSTEP], off0, off1);
    wire stat_clr = reg_wr && (reg_addr == DCAG_REG_STAT) && reg_wdata[DCAG_STAT_DONE];

    logic [23:0] next_rdata;
    always_comb begin
        case (reg_addr)
            DCAG_REG_COUNT: next_rdata = src_cnt;
            DCAG_REG_SRC: next_rdata = src_ptr;
            DCAG_REG_DST: next_rdata = dst_ptr;
            DCAG_REG_CTRL: next_rdata = {15'h0000, ctrl};
            DCAG_REG_OFF0: next_rdata = off0;
            DCAG_REG_OFF1: next_rdata = off1;
            DCAG_REG_STAT: next_rdata = {21'h000000, ~fifo_out_valid, ~fifo_in_ready, done};
            DCAG_REG_DCNT: next_rdata = dst_cnt;
            default: next_rdata = 24'h000000;
        endcase
    end

    // ---------------------------------------------------------
    // Registers
    // ---------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            preload <= DCAG_RESET;
            src_cnt <= DCAG_RESET;
            dst_cnt <= DCAG_RESET;
        end else if (wr_cnt) begin
            preload <= reg_wdata;
            src_cnt <= reg_wdata;
            dst_cnt <= reg_wdata;
        end else if (step) begin
            src_cnt <= next_src_cnt;
            dst_cnt <= next_dst_cnt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_ptr <= DCAG_RESET;
        end else if (reg_wr && reg_addr == DCAG_REG_SRC) begin
            src_ptr <= reg_wdata;
        end else if (step) begin
            src_ptr <= next_src_ptr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dst_ptr <= DCAG_RESET;
        end else if (reg_wr && reg_addr == DCAG_REG_DST) begin
            dst_ptr <= reg_wdata;
        end else if (step) begin
            dst_ptr <= next_dst_ptr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl <= 9'h000;
            off0 <= DCAG_RESET;
            off1 <= DCAG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == DCAG_REG_CTRL) ctrl <= reg_wdata[8:0];
            if (reg_addr == DCAG_REG_OFF0) off0 <= reg_wdata;
            if (reg_addr == DCAG_REG_OFF1) off1 <= reg_wdata;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done <= 1'b0;
        end else if (step && src_last) begin
            done <= 1'b1;
        end else if (stat_clr) begin
            done <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 24'h000000;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 24'h000000;
        end
    end

    // ---------------------------------------------------------
    // Address FIFO
    // ---------------------------------------------------------
    dcag_fifo #(
        .WIDTH(48),
        .DEPTH(DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(step),
        .in_ready(fifo_in_ready),
        .in_data({src_ptr, dst_ptr}),
        .out_valid(fifo_out_valid),
        .out_ready(addr_ready),
        .out_data(fifo_out)
    );

    assign xfer_ready = fifo_in_ready && run;
    assign addr_valid = fifo_out_valid;
    assign addr_src = fifo_out[47:24];
    assign addr_dst = fifo_out[23:0];

    // ---------------------------------------------------------
    // Checks
    // ---------------------------------------------------------
    AST_WR_PRELOAD: assert property (@(posedge ref_clk) disable iff (rst)
        wr_cnt |=> (preload == $past(reg_wdata)) && (src_cnt == preload) && (dst_cnt == preload))
        else $error("Counter write not captured");

    AST_A_DEC: assert property (@(posedge ref_clk) disable iff (rst)
        step && !wr_cnt && smode == DCAG_MODE_A && !src_last |=> src_cnt == $past(src_cnt) - 24'h000001)
        else $error("Single counter did not decrement");

    AST_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
        step && !wr_cnt && src_last |=> (src_cnt == preload) && done)
        else $error("Counter not reloaded at block end");

    AST_B_LOW: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && smode == DCAG_MODE_B && src_cnt[11:0] != 12'h000
        |=> src_ptr == $past(src_ptr) + 24'h000001)
        else $error("Low step did not add one");

    AST_B_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && smode == DCAG_MODE_B && src_cnt[11:0] == 12'h000 && src_cnt[23:12] != 12'h000
        |=> src_cnt[23:12] == $past(src_cnt[23:12]) - 12'h001 && src_cnt[11:0] == preload[11:0]
            && src_ptr == $past(src_ptr) + $past(off0))
        else $error("Dual high step wrong");

    AST_C_MID: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && smode == DCAG_MODE_C && src_cnt[5:0] == 6'h00 && src_cnt[11:6] != 6'h00
        |=> src_cnt[11:6] == $past(src_cnt[11:6]) - 6'h01 && src_cnt[23:12] == $past(src_cnt[23:12])
            && src_ptr == $past(src_ptr) + $past(off0))
        else $error("Middle step wrong");

    AST_D_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && smode == DCAG_MODE_D && src_cnt[17:0] == 18'h00000 && src_cnt[23:18] != 6'h00
        |=> src_cnt[23:18] == $past(src_cnt[23:18]) - 6'h01 && src_cnt[17:0] == preload[17:0]
            && src_ptr == $past(src_ptr) + $past(off1))
        else $error("High step wrong");

    AST_E_LOW: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && smode == DCAG_MODE_E && src_cnt[11:0] != 12'h000
        |=> src_cnt[23:12] == $past(src_cnt[23:12]) && src_cnt[11:0] == $past(src_cnt[11:0]) - 12'h001)
        else $error("Low field of layout E wrong");

    AST_DST_STEP: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && dmode == DCAG_MODE_C && dst_cnt[5:0] != 6'h00
        |=> dst_ptr == $past(dst_ptr) + 24'h000001)
        else $error("Destination low step did not add one");

    AST_DST_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && dmode == DCAG_MODE_A && !ctrl[DCAG_CTRL_DSTEP] |=> dst_ptr == $past(dst_ptr))
        else $error("Constant destination moved");

    AST_B_LAST: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && smode == DCAG_MODE_B && src_last
        |=> src_cnt == preload && src_ptr == $past(src_ptr) + $past(off0))
        else $error("Dual block end wrong");

    AST_T_LAST: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && src_last
            && (smode == DCAG_MODE_C || smode == DCAG_MODE_D || smode == DCAG_MODE_E)
        |=> src_cnt == preload && src_ptr == $past(src_ptr) + $past(off1))
        else $error("Triple block end wrong");

    AST_C_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && smode == DCAG_MODE_C && src_cnt[11:0] == 12'h000 && src_cnt[23:12] != 12'h000
        |=> src_cnt[23:12] == $past(src_cnt[23:12]) - 12'h001 && src_cnt[11:0] == preload[11:0]
            && src_ptr == $past(src_ptr) + $past(off1))
        else $error("Layout C high step wrong");

    AST_D_LOW: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && smode == DCAG_MODE_D && src_cnt[5:0] != 6'h00
        |=> src_cnt[23:6] == $past(src_cnt[23:6]) && src_cnt[5:0] == $past(src_cnt[5:0]) - 6'h01)
        else $error("Low field of layout D wrong");

    AST_E_MID: assert property (@(posedge ref_clk) disable iff (rst)
        step && !reg_wr && smode == DCAG_MODE_E && src_cnt[11:0] == 12'h000 && src_cnt[17:12] != 6'h00
        |=> src_cnt[17:12] == $past(src_cnt[17:12]) - 6'h01 && src_cnt[11:0] == preload[11:0]
            && src_cnt[23:18] == $past(src_cnt[23:18]) && src_ptr == $past(src_ptr) + $past(off0))
        else $error("Layout E middle step wrong");

    AST_STALL: assert property (@(posedge ref_clk) disable iff (rst)
        !fifo_in_ready && !reg_wr |=> $stable(src_cnt))
        else $error("Counted while FIFO full");
endmodule

`default_nettype wire

//--- tb/dcag_sink.sv
// Address sink standing in for the memories behind the channel
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------
// Sink model: prompt, slow or stalled acceptance
// ---------------------------------------------------------
module dcag_sink (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic slow,
    input wire logic addr_valid,
    input wire logic [23:0] addr_src,
    input wire logic [23:0] addr_dst,
    output logic addr_ready,
    output logic got,
    output logic [23:0] got_src,
    output logic [23:0] got_dst
);
    logic phase;

    // Ready toggles in slow mode so the FIFO sees gaps
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase <= 1'b0;
            addr_ready <= 1'b0;
            got <= 1'b0;
            got_src <= 24'h000000;
            got_dst <= 24'h000000;
        end else begin
            phase <= ~phase;
            addr_ready <= !stall && (!slow || phase);
            got <= addr_valid && addr_ready;
            if (addr_valid && addr_ready) begin
                got_src <= addr_src;
                got_dst <= addr_dst;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the channel counter and address generator
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import dcag_pkg::*;
    localparam int DEPTH = 16;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, xfer_req = 1'b0;
    logic stall = 1'b0, slow = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [23:0] reg_wdata = 24'h000000;
    logic [23:0] reg_rdata, addr_src, addr_dst, got_src, got_dst;
    logic xfer_ready, addr_valid, addr_ready, got;
    logic [23:0] seen_src[$], seen_dst[$];
    int errors = 0, n_checks = 0, cycles = 0;

    // ---------------------------------------------------------
    // Clock, instances, collection and hang guard
    // ---------------------------------------------------------
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    dcag_channel #(.DEPTH(DEPTH)) DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .xfer_req(xfer_req), .xfer_ready(xfer_ready), .addr_valid(addr_valid),
        .addr_ready(addr_ready), .addr_src(addr_src), .addr_dst(addr_dst));

    dcag_sink sink (.ref_clk(ref_clk), .rst(rst), .stall(stall), .slow(slow),
        .addr_valid(addr_valid), .addr_src(addr_src), .addr_dst(addr_dst),
        .addr_ready(addr_ready), .got(got), .got_src(got_src), .got_dst(got_dst));

    always @(posedge ref_clk) begin
        if (got === 1'b1) begin
            seen_src.push_back(got_src);
            seen_dst.push_back(got_dst);
        end
    end

    // Ceiling well above the roughly one thousand cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            complete_run();
        end
    end

    // ---------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_checks++;
        if (g !== e) begin
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
            errors++;
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [23:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [23:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // Holds the request and counts edges at which it was taken
    task automatic steps(input int n, input int limit, output int taken);
        int k;
        taken = 0;
        k = 0;
        @(posedge ref_clk);
        xfer_req <= 1'b1;
        while (taken < n && k < limit) begin
            @(negedge ref_clk);
            if (xfer_ready === 1'b1) taken++;
            k++;
            @(posedge ref_clk);
        end
        xfer_req <= 1'b0;
    endtask

    task automatic wait_seen(input int n);
        int k;
        k = 0;
        while (seen_src.size() < n && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
    endtask

    // ---------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------
    task automatic reg_test();
        logic [23:0] v;
        rd(DCAG_REG_COUNT, v);
        chk(v, DCAG_RESET);
        rd(DCAG_REG_STAT, v);
        chk(v, 24'h000004);
        wr(DCAG_REG_OFF0, 24'hA5A5A5);
        rd(DCAG_REG_OFF0, v);
        chk(v, 24'hA5A5A5);
        wr(DCAG_REG_CTRL, 24'hFFFE00);
        rd(DCAG_REG_CTRL, v);
        chk(v, 24'h000000);
        wr(DCAG_REG_DCNT, 24'hFFFFFF);
        rd(DCAG_REG_DCNT, v);
        chk(v, 24'h000000);
        $display("test registers finished");
    endtask

    // Expected walk is nested loops: low inside middle inside high
    task automatic run_block(input logic [2:0] mode, input int nl, input int nm, input int nh,
                             input logic [23:0] pre, input logic dstep, input logic dsame);
        logic [23:0] a, v;
        int n, taken, i;
        a = 24'h000100;
        i = 0;
        n = (nl + 1) * (nm + 1) * (nh + 1);
        seen_src.delete();
        seen_dst.delete();
        wr(DCAG_REG_COUNT, pre);
        wr(DCAG_REG_SRC, a);
        wr(DCAG_REG_DST, 24'h008000);
        wr(DCAG_REG_OFF0, 24'h000020);
        wr(DCAG_REG_OFF1, 24'h000400);
        wr(DCAG_REG_STAT, 24'h000001);
        wr(DCAG_REG_CTRL, (24'h1 << DCAG_CTRL_RUN) | (24'h1 << DCAG_CTRL_SSTEP) |
           (dstep ? (24'h1 << DCAG_CTRL_DSTEP) : 24'h0) |
           (dsame ? ({21'h0, mode} << DCAG_CTRL_DMODE) : 24'h0) | {21'h0, mode});
        steps(n, 4 * n + 50, taken);
        wait_seen(n);
        chk(24'(seen_src.size()), 24'(n));
        for (int h = 0; h <= nh; h++) begin
            for (int m = 0; m <= nm; m++) begin
                for (int l = 0; l <= nl; l++) begin
                    if (i < seen_src.size()) begin
                        chk(seen_src[i], a);
                        chk(seen_dst[i], dsame ? a + 24'h007F00 : (dstep ? 24'h008000 + 24'(i) : 24'h008000));
                    end
                    if (l < nl || mode == DCAG_MODE_A || mode > DCAG_MODE_E) a = a + 24'h1;
                    else if (mode == DCAG_MODE_B || m < nm) a = a + 24'h000020;
                    else a = a + 24'h000400;
                    i++;
                end
            end
        end
        wr(DCAG_REG_CTRL, 24'h000000);
        rd(DCAG_REG_COUNT, v);
        chk(v, pre);
        rd(DCAG_REG_SRC, v);
        chk(v, a);
        rd(DCAG_REG_DST, v);
        chk(v, dsame ? a + 24'h007F00 : (dstep ? 24'h008000 + 24'(n) : 24'h008000));
        rd(DCAG_REG_STAT, v);
        chk({23'h0, v[DCAG_STAT_DONE]}, 24'h000001);
        $display("test mode %0d finished", mode);
    endtask

    // Stalled sink: FIFO takes exactly its depth, then drains in order
    task automatic fifo_fill();
        logic [23:0] v;
        int taken;
        seen_src.delete();
        seen_dst.delete();
        @(posedge ref_clk);
        stall <= 1'b1;
        wr(DCAG_REG_COUNT, 24'h0000FF);
        wr(DCAG_REG_SRC, 24'h000000);
        wr(DCAG_REG_CTRL, (24'h1 << DCAG_CTRL_RUN) | (24'h1 << DCAG_CTRL_SSTEP));
        steps(DEPTH + 8, DEPTH + 8, taken);
        chk(taken[23:0], 24'(DEPTH));
        rd(DCAG_REG_STAT, v);
        chk({23'h0, v[DCAG_STAT_FULL]}, 24'h000001);
        @(posedge ref_clk);
        stall <= 1'b0;
        wait_seen(DEPTH);
        for (int i = 0; i < DEPTH; i++) begin
            chk(i < seen_src.size() ? seen_src[i] : 24'hFFFFFF, i[23:0]);
        end
        rd(DCAG_REG_STAT, v);
        chk({23'h0, v[DCAG_STAT_EMPTY]}, 24'h000001);
        wr(DCAG_REG_CTRL, 24'h000000);
        $display("test fifo finished");
    endtask

    // ---------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        reg_test();
        run_block(DCAG_MODE_A, 5, 0, 0, 24'h000005, 1'b0, 1'b0);
        @(posedge ref_clk);
        slow <= 1'b1;
        run_block(DCAG_MODE_B, 2, 0, 1, 24'h001002, 1'b1, 1'b0);
        @(posedge ref_clk);
        slow <= 1'b0;
        run_block(DCAG_MODE_C, 2, 1, 1, 24'h001042, 1'b1, 1'b1);
        run_block(DCAG_MODE_D, 2, 64, 1, 24'h041002, 1'b1, 1'b0);
        run_block(DCAG_MODE_E, 64, 1, 1, 24'h041040, 1'b1, 1'b0);
        run_block(3'h5, 3, 0, 0, 24'h000003, 1'b0, 1'b0);
        fifo_fill();
        complete_run();
    end
endmodule
`default_nettype wire
